// File: design/scr_map.svh
// Offsets, field positions, reset values and timing counts of the safety configuration registers.
`ifndef SCR_MAP_SVH
`define SCR_MAP_SVH
// Register selectors on the serial command port.
`define SCR_SEL_DEVICE_CONFIG_4 2'h0
`define SCR_SEL_SAFETY_CONFIG_1 2'h1
`define SCR_SEL_SAFETY_CONFIG_2 2'h2
`define SCR_SEL_IDENTITY 2'h3
// Writable bits; every other bit is reserved.
`define SCR_MASK_DEVICE_CONFIG_4 8'h33
`define SCR_MASK_SAFETY_CONFIG_1 8'h3F
`define SCR_MASK_SAFETY_CONFIG_2 8'hBF
// Reset values.
`define SCR_RST_DEVICE_CONFIG_4 8'h03
`define SCR_RST_SAFETY_CONFIG_1 8'h00
`define SCR_RST_SAFETY_CONFIG_2 8'h00
// Field positions.
`define SCR_SLT_LSB 4
`define SCR_RRD_LSB 0
`define SCR_STO_LSB 4
`define SCR_LTH_LSB 0
`define SCR_CLKW_BIT 7
`define SCR_ENDRV_BIT 2
`define SCR_ABIST_BIT 3
`define SCR_NRST_BIT 1
`define SCR_NSAFE_BIT 0
`define SCR_ID_FUSE_BIT 4
// Identity value; arbitrary, bit 4 is replaced by the delay-order fuse.
`define SCR_ID_BASE 8'hA5
// Supply-low threshold in units of 0.1 V.
`define SCR_SLT_00 7'h3E
`define SCR_SLT_01 7'h48
`define SCR_SLT_1X 7'h52
// Timing in microseconds (time-out 3 in nanoseconds) and clock rate in MHz.
`define SCR_CLK_MHZ 125
`define SCR_EXT0_US 2000
`define SCR_EXT1_US 11000
`define SCR_EXT2_US 21000
`define SCR_EXT3_US 31000
`define SCR_TO0_US 640000
`define SCR_TO1_US 320000
`define SCR_TO2_US 5000
`define SCR_TO3_NS 1250000
// Cycle counts derived from the times.
`define SCR_EXT0_CYC (`SCR_EXT0_US * `SCR_CLK_MHZ)
`define SCR_EXT1_CYC (`SCR_EXT1_US * `SCR_CLK_MHZ)
`define SCR_EXT2_CYC (`SCR_EXT2_US * `SCR_CLK_MHZ)
`define SCR_EXT3_CYC (`SCR_EXT3_US * `SCR_CLK_MHZ)
`define SCR_TO0_CYC (`SCR_TO0_US * `SCR_CLK_MHZ)
`define SCR_TO1_CYC (`SCR_TO1_US * `SCR_CLK_MHZ)
`define SCR_TO2_CYC (`SCR_TO2_US * `SCR_CLK_MHZ)
`define SCR_TO3_CYC ((`SCR_TO3_NS * `SCR_CLK_MHZ) / 1000)
`endif

// File: design/scr_pkg.sv
// Types shared by the safety configuration register block.
package scr_pkg;
    typedef enum logic [3:0] {
        OP_RESET = 4'b0001,
        OP_DIAG = 4'b0010,
        OP_ACTIVE = 4'b0100,
        OP_SAFE = 4'b1000
    } op_state_type;

    typedef enum logic [2:0] {
        SF_IDLE = 3'b001,
        SF_RUN = 3'b010,
        SF_LOCK = 3'b100
    } safe_fsm_type;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [1:0] sel;
        logic [7:0] data;
    } reg_cmd_type;

    typedef struct packed {
        logic clk_warn;
        logic endrv_err;
        logic mcu_reset_out_n_err;
        logic abist_fail;
    } fault_type;
endpackage : scr_pkg

// File: design/scr_timer.sv
// One-shot down counter that signals when a loaded count has elapsed.
`timescale 1ns/10ps
module scr_timer (
    // Clock and reset
    input wire logic clock_in,
    input wire logic srst_in,
    // Control
    input wire logic start_in,
    input wire logic abort_in,
    input wire logic [26:0] load_in,
    // Status
    output logic busy_out,
    output logic done_out
);
    logic [26:0] cnt_q, cnt_d;
    logic busy_q, busy_d;
    logic done_q, done_d;

    always_comb begin
        cnt_d = cnt_q;
        busy_d = busy_q;
        done_d = 1'b0;
        if (abort_in) begin
            busy_d = 1'b0;
        end else if (start_in) begin
            cnt_d = load_in;
            busy_d = 1'b1;
        end else if (busy_q) begin
            if (cnt_q <= 27'h000_0001) begin
                busy_d = 1'b0;
                done_d = 1'b1;
            end else begin
                cnt_d = cnt_q - 27'h000_0001;
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            cnt_q <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            busy_q <= busy_d;
            done_q <= done_d;
        end
    end

    assign busy_out = busy_q;
    assign done_out = done_q;
endmodule : scr_timer

// File: design/scr_crc8.sv
// CRC-8 (polynomial x^8+x^2+x+1, seed all ones) over the configuration bytes.
`timescale 1ns/10ps
module scr_crc8 (
    // Data
    input wire logic [23:0] data_in,
    // Checksum
    output logic [7:0] crc_out
);
    always_comb begin
        logic [7:0] c;
        logic fb;
        c = 8'hFF;
        fb = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            fb = c[7] ^ data_in[i];
            c = {c[6:0], 1'b0} ^ (fb ? 8'h07 : 8'h00);
        end
        crc_out = c;
    end
endmodule : scr_crc8

// File: design/safety_config_registers.sv
// Safety configuration registers with their command port, timers and transition requests.
`timescale 1ns/10ps
`include "scr_map.svh"
// Operation
// - Writes only in diagnostic state, lock clear.
// - Register contents feed the configuration checksum.
// - Supply-low threshold 6.2/7.2/8.2 V, reset 00b.
// - Reset-release delay field, resets to 11b.
// - Fuse 0: delays 2, 11, 21, 31 ms.
// - Fuse 1: delay codes in reverse order.
// - Fuse latched, shown as identity bit 4.
// - Safe time-out 640/320/5/1.25 ms, reset 00b.
// - Lock threshold resets 0, compared to errors.
// - Disable clear: time-out always goes to reset.
// - Disable set, count within threshold: reset.
// - Disable set, count above threshold: stay locked.
// - Reset transition beats safe on reset-output error.
// - Clock warning enable moves diag/active to safe.
module safety_config_registers import scr_pkg::*; #(
    parameter logic [26:0] EXT0_CYC = 27'(`SCR_EXT0_CYC),
    parameter logic [26:0] EXT1_CYC = 27'(`SCR_EXT1_CYC),
    parameter logic [26:0] EXT2_CYC = 27'(`SCR_EXT2_CYC),
    parameter logic [26:0] EXT3_CYC = 27'(`SCR_EXT3_CYC),
    parameter logic [26:0] TO0_CYC = 27'(`SCR_TO0_CYC),
    parameter logic [26:0] TO1_CYC = 27'(`SCR_TO1_CYC),
    parameter logic [26:0] TO2_CYC = 27'(`SCR_TO2_CYC),
    parameter logic [26:0] TO3_CYC = 27'(`SCR_TO3_CYC)
) (
    // Clock and power-on reset
    input wire logic clock_in,
    input wire logic srst_in,
    // Serial command port
    input wire reg_cmd_type cmd_in,
    output logic [7:0] rd_data_out,
    output logic rd_valid_out,
    output logic wr_ack_out,
    output logic wr_reject_out,
    // Device state and events
    input wire op_state_type op_state_in,
    input wire logic cfg_lock_in,
    input wire logic delay_order_fuse_in,
    input wire logic [3:0] device_error_count_in,
    input wire logic safe_timeout_disable_in,
    input wire fault_type faults_in,
    input wire logic reset_ext_start_in,
    // Configuration and decisions
    output logic [6:0] supply_low_threshold_out,
    output logic [7:0] safety_config_2_out,
    output logic [7:0] config_checksum_out,
    output logic mcu_reset_out_n,
    output logic go_safe_out,
    output logic go_reset_out,
    output logic safe_locked_out
);
    logic [7:0] device_config_4_q, device_config_4_d;
    logic [7:0] safety_config_1_q, safety_config_1_d;
    logic [7:0] safety_config_2_q, safety_config_2_d;
    logic [7:0] rd_data_q, rd_data_d;
    logic rd_valid_q, rd_valid_d;
    logic wr_ack_q, wr_ack_d;
    logic wr_reject_q, wr_reject_d;
    logic fuse_q, fuse_d;
    logic fuse_seen_q, fuse_seen_d;
    // Arbitrary identity value; bit 4 is replaced by the latched fuse.
    localparam logic [7:0] id_base = `SCR_ID_BASE;
    logic [7:0] identity;
    logic wr_ok;

    // Register file and command port.
    assign identity = {id_base[7:5], fuse_q, id_base[3:0]};
    assign wr_ok = (op_state_in == OP_DIAG) && !cfg_lock_in;

    always_comb begin
        device_config_4_d = device_config_4_q;
        safety_config_1_d = safety_config_1_q;
        safety_config_2_d = safety_config_2_q;
        // A read in the same cycle as a write returns the old contents.
        wr_ack_d = cmd_in.wr && wr_ok && (cmd_in.sel != `SCR_SEL_IDENTITY);
        wr_reject_d = cmd_in.wr && !wr_ack_d;
        if (wr_ack_d) begin
            case (cmd_in.sel)
                `SCR_SEL_DEVICE_CONFIG_4: device_config_4_d = cmd_in.data & `SCR_MASK_DEVICE_CONFIG_4;
                `SCR_SEL_SAFETY_CONFIG_1: safety_config_1_d = cmd_in.data & `SCR_MASK_SAFETY_CONFIG_1;
                `SCR_SEL_SAFETY_CONFIG_2: safety_config_2_d = cmd_in.data & `SCR_MASK_SAFETY_CONFIG_2;
                default: begin
                end
            endcase
        end
        rd_valid_d = cmd_in.rd;
        case (cmd_in.sel)
            `SCR_SEL_DEVICE_CONFIG_4: rd_data_d = device_config_4_q;
            `SCR_SEL_SAFETY_CONFIG_1: rd_data_d = safety_config_1_q;
            `SCR_SEL_SAFETY_CONFIG_2: rd_data_d = safety_config_2_q;
            default: rd_data_d = identity;
        endcase
        if (!cmd_in.rd) begin
            rd_data_d = rd_data_q;
        end
    end

    // The fuse is captured once, on the first clock after power-on reset releases.
    always_comb begin
        fuse_d = fuse_q;
        fuse_seen_d = 1'b1;
        if (!fuse_seen_q) begin
            fuse_d = delay_order_fuse_in;
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            device_config_4_q <= `SCR_RST_DEVICE_CONFIG_4;
            safety_config_1_q <= `SCR_RST_SAFETY_CONFIG_1;
            safety_config_2_q <= `SCR_RST_SAFETY_CONFIG_2;
            rd_data_q <= 8'h00;
            rd_valid_q <= 1'b0;
            wr_ack_q <= 1'b0;
            wr_reject_q <= 1'b0;
            fuse_q <= 1'b0;
            fuse_seen_q <= 1'b0;
        end else begin
            device_config_4_q <= device_config_4_d;
            safety_config_1_q <= safety_config_1_d;
            safety_config_2_q <= safety_config_2_d;
            rd_data_q <= rd_data_d;
            rd_valid_q <= rd_valid_d;
            wr_ack_q <= wr_ack_d;
            wr_reject_q <= wr_reject_d;
            fuse_q <= fuse_d;
            fuse_seen_q <= fuse_seen_d;
        end
    end

    // Checksum over the three configuration registers.
    // It lags the registers by one cycle, so a reader sees it once a write has settled.
    logic [7:0] crc_now;
    logic [7:0] crc_q, crc_d;

    scr_crc8 u_crc (
        .data_in({device_config_4_q, safety_config_1_q, safety_config_2_q}),
        .crc_out(crc_now)
    );

    // Decoded configuration.
    logic [1:0] slt_code, rrd_code, sto_code;
    logic [3:0] lock_th;
    logic [6:0] slt_q, slt_d;
    logic [1:0] eff_rrd;
    logic [26:0] ext_load, to_load;

    assign slt_code = device_config_4_q[`SCR_SLT_LSB +: 2];
    assign rrd_code = device_config_4_q[`SCR_RRD_LSB +: 2];
    assign sto_code = safety_config_1_q[`SCR_STO_LSB +: 2];
    assign lock_th = safety_config_1_q[`SCR_LTH_LSB +: 4];
    // A set fuse reverses the code order, which is the bitwise complement.
    assign eff_rrd = fuse_q ? ~rrd_code : rrd_code;

    always_comb begin
        crc_d = crc_now;
        case (slt_code)
            2'b00: slt_d = `SCR_SLT_00;
            2'b01: slt_d = `SCR_SLT_01;
            default: slt_d = `SCR_SLT_1X;
        endcase
        case (eff_rrd)
            2'b00: ext_load = EXT0_CYC;
            2'b01: ext_load = EXT1_CYC;
            2'b10: ext_load = EXT2_CYC;
            default: ext_load = EXT3_CYC;
        endcase
        case (sto_code)
            2'b00: to_load = TO0_CYC;
            2'b01: to_load = TO1_CYC;
            2'b10: to_load = TO2_CYC;
            default: to_load = TO3_CYC;
        endcase
    end

    // Reset-release extension.
    logic ext_busy;
    logic rst_n_q, rst_n_d;

    scr_timer u_ext_timer (
        .clock_in(clock_in),
        .srst_in(srst_in),
        .start_in(reset_ext_start_in),
        .abort_in(1'b0),
        .load_in(ext_load),
        .busy_out(ext_busy),
        .done_out()
    );

    // The start pulse itself pulls the output low, so a restart never lets it rise.
    always_comb begin
        rst_n_d = !(reset_ext_start_in || ext_busy);
    end

    // Safe-state time-out and lock.
    safe_fsm_type sf_q, sf_d;
    logic to_start, to_busy, to_done;
    logic in_safe, may_leave;
    logic locked_q, locked_d;

    assign in_safe = (op_state_in == OP_SAFE);
    assign to_start = in_safe && (sf_q == SF_IDLE);
    // Without the disable bit the threshold is not consulted at all.
    assign may_leave = !safe_timeout_disable_in || (device_error_count_in <= lock_th);

    scr_timer u_safe_timer (
        .clock_in(clock_in),
        .srst_in(srst_in),
        .start_in(to_start),
        .abort_in(!in_safe),
        .load_in(to_load),
        .busy_out(to_busy),
        .done_out(to_done)
    );

    // Leaving the safe state at any point aborts the timer and clears the lock.
    always_comb begin
        sf_d = sf_q;
        case (sf_q)
            SF_IDLE: begin
                if (in_safe) begin
                    sf_d = SF_RUN;
                end
            end
            SF_RUN: begin
                if (!in_safe) begin
                    sf_d = SF_IDLE;
                end else if (to_done && !may_leave) begin
                    sf_d = SF_LOCK;
                end else if (to_done || !to_busy) begin
                    sf_d = SF_IDLE;
                end
            end
            SF_LOCK: begin
                if (!in_safe) begin
                    sf_d = SF_IDLE;
                end
            end
            default: sf_d = SF_IDLE;
        endcase
        locked_d = (sf_d == SF_LOCK);
    end

    // Transition requests.
    // A reset request overrides every safe request raised in the same cycle.
    logic go_safe_q, go_safe_d;
    logic go_reset_q, go_reset_d;
    logic diag_or_active, mcu_reset_out_n_rst;

    assign diag_or_active = (op_state_in == OP_DIAG) || (op_state_in == OP_ACTIVE);
    assign mcu_reset_out_n_rst = faults_in.mcu_reset_out_n_err && safety_config_2_q[`SCR_NRST_BIT] && (diag_or_active || in_safe);

    always_comb begin
        go_reset_d = mcu_reset_out_n_rst || (in_safe && (sf_q == SF_RUN) && to_done && may_leave);
        go_safe_d = 1'b0;
        if (diag_or_active) begin
            go_safe_d = (faults_in.clk_warn && safety_config_2_q[`SCR_CLKW_BIT])
                || (faults_in.endrv_err && safety_config_2_q[`SCR_ENDRV_BIT])
                || (faults_in.abist_fail && safety_config_2_q[`SCR_ABIST_BIT])
                || (faults_in.mcu_reset_out_n_err && safety_config_2_q[`SCR_NSAFE_BIT]);
        end
        if (go_reset_d) begin
            go_safe_d = 1'b0;
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            crc_q <= 8'h00;
            slt_q <= `SCR_SLT_00;
            rst_n_q <= 1'b0;
            sf_q <= SF_IDLE;
            locked_q <= 1'b0;
            go_safe_q <= 1'b0;
            go_reset_q <= 1'b0;
        end else begin
            crc_q <= crc_d;
            slt_q <= slt_d;
            rst_n_q <= rst_n_d;
            sf_q <= sf_d;
            locked_q <= locked_d;
            go_safe_q <= go_safe_d;
            go_reset_q <= go_reset_d;
        end
    end

    assign rd_data_out = rd_data_q;
    assign rd_valid_out = rd_valid_q;
    assign wr_ack_out = wr_ack_q;
    assign wr_reject_out = wr_reject_q;
    assign supply_low_threshold_out = slt_q;
    assign safety_config_2_out = safety_config_2_q;
    assign config_checksum_out = crc_q;
    assign mcu_reset_out_n = rst_n_q;
    assign go_safe_out = go_safe_q;
    assign go_reset_out = go_reset_q;
    assign safe_locked_out = locked_q;
endmodule : safety_config_registers

// File: verification/scr_checker.sv
// Assertion checker for the safety configuration register block.
`timescale 1ns/10ps
module scr_checker import scr_pkg::*; (
    // Clock and reset
    input wire logic clock_in,
    input wire logic srst_in,
    // Command port
    input wire reg_cmd_type cmd_in,
    input wire logic rd_valid_out,
    input wire logic wr_ack_out,
    input wire logic wr_reject_out,
    // Device state and outputs
    input wire op_state_type op_state_in,
    input wire logic cfg_lock_in,
    input wire fault_type faults_in,
    input wire logic reset_ext_start_in,
    input wire logic [6:0] supply_low_threshold_out,
    input wire logic [7:0] safety_config_2_out,
    input wire logic [7:0] config_checksum_out,
    input wire logic mcu_reset_out_n,
    input wire logic go_safe_out,
    input wire logic go_reset_out,
    input wire logic safe_locked_out
);
    logic [7:0] wdata_d, wdata_q;
    logic [6:0] thr_exp;
    // Keeps the data of the last write so later cycles can compare against it.
    always_comb begin
        wdata_d = cmd_in.wr ? cmd_in.data : wdata_q;
        case (wdata_q[5:4])
            2'h0: thr_exp = 7'h3E;
            2'h1: thr_exp = 7'h48;
            default: thr_exp = 7'h52;
        endcase
    end
    always_ff @(posedge clock_in) begin
        wdata_q <= wdata_d;
    end
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (srst_in);
    sequence s_wr_ok;
        cmd_in.wr && op_state_in == OP_DIAG && !cfg_lock_in && cmd_in.sel != 2'h3;
    endsequence
    sequence s_wr_bad;
        cmd_in.wr && !(op_state_in == OP_DIAG && !cfg_lock_in && cmd_in.sel != 2'h3);
    endsequence
    a_rd_answer: assert property (cmd_in.rd |=> rd_valid_out) else $error("read not answered");
    a_wr_accept: assert property (s_wr_ok |=> wr_ack_out && !wr_reject_out)
        else $error("allowed write not acknowledged");
    a_wr_refuse: assert property (s_wr_bad |=> wr_reject_out && !wr_ack_out)
        else $error("forbidden write not refused");
    a_cfg2_write: assert property (s_wr_ok ##0 cmd_in.sel == 2'h2 |-> ##[1:2] safety_config_2_out == (wdata_q & 8'hBF))
        else $error("safety_config_2 write mismatch");
    a_thr_map: assert property (s_wr_ok ##0 cmd_in.sel == 2'h0 |-> ##[1:2] supply_low_threshold_out == thr_exp)
        else $error("supply threshold mismatch");
    a_reset_init: assert property ($fell(srst_in) |-> safety_config_2_out == 8'h00 && supply_low_threshold_out == 7'h3E
        && !go_safe_out && !go_reset_out && !safe_locked_out) else $error("reset values wrong");
    a_crc_track: assert property ($changed(safety_config_2_out) |=> $changed(config_checksum_out))
        else $error("checksum did not follow register");
    a_reset_first: assert property (go_reset_out |-> !go_safe_out) else $error("safe beat reset");
    a_clk_warn: assert property (op_state_in inside {OP_DIAG, OP_ACTIVE} && safety_config_2_out[7] && faults_in.clk_warn
        && !(safety_config_2_out[1] && faults_in.mcu_reset_out_n_err) |=> go_safe_out) else $error("clock warning ignored");
    a_lock_hold: assert property (safe_locked_out && $past(op_state_in) == OP_SAFE && !$past(faults_in.mcu_reset_out_n_err)
        |-> !go_reset_out) else $error("locked device left safe state");
    a_ext_low: assert property (reset_ext_start_in |=> !mcu_reset_out_n [*8])
        else $error("reset extension too short");
endmodule : scr_checker

bind safety_config_registers scr_checker chk (.clock_in, .srst_in, .cmd_in, .rd_valid_out, .wr_ack_out,
    .wr_reject_out, .op_state_in, .cfg_lock_in, .faults_in, .reset_ext_start_in, .supply_low_threshold_out,
    .safety_config_2_out, .config_checksum_out, .mcu_reset_out_n, .go_safe_out, .go_reset_out, .safe_locked_out);

// File: verification/scr_mcu_model.sv
// Microcontroller model that issues register commands on the serial command port.
`timescale 1ns/10ps
module scr_mcu_model import scr_pkg::*; (
    // Clock
    input wire logic clock_in,
    // Command port
    output reg_cmd_type cmd_out,
    input wire logic [7:0] rd_data_in,
    input wire logic rd_valid_in,
    input wire logic wr_ack_in,
    input wire logic wr_reject_in
);
    initial cmd_out = 12'h0A5;
    // A write is taken at one edge; its response is read just after that edge.
    task automatic write(input logic [1:0] sel, input logic [7:0] data, output logic [1:0] resp);
        @(posedge clock_in);
        #1 cmd_out = {1'b1, 1'b0, sel, data};
        @(posedge clock_in);
        #1 resp = {wr_ack_in, wr_reject_in};
        cmd_out = {1'b0, 1'b0, ~sel, ~data};
    endtask : write
    task automatic read(input logic [1:0] sel, output logic [8:0] resp);
        @(posedge clock_in);
        #1 cmd_out = {1'b0, 1'b1, sel, ~cmd_out.data};
        @(posedge clock_in);
        #1 resp = {rd_valid_in, rd_data_in};
        cmd_out = {1'b0, 1'b0, ~sel, ~cmd_out.data};
    endtask : read
endmodule : scr_mcu_model

// File: verification/tb_top.sv
// Self-checking testbench of the safety configuration register block.
`timescale 1ns/10ps
`include "scr_map.svh"
module tb_top import scr_pkg::*;;
    typedef struct {
        op_state_type op;
        logic lock;
        logic [1:0] sel;
        logic [7:0] data;
        logic ack;
        logic [7:0] rd;
        logic [6:0] thr;
    } row_type;
    logic clock_in, srst_in, lock, fuse, dis, ext_start;
    reg_cmd_type cmd;
    op_state_type op;
    fault_type faults;
    logic [3:0] err_cnt;
    logic [7:0] rd_data, cfg2, csum;
    logic [6:0] thr;
    logic rd_valid, wr_ack, wr_rej, mcu_rst_n, go_safe, go_reset, locked;
    logic [1:0] wresp;
    logic [8:0] rresp;
    int n_fail = 0, samples_checked = 0, n;
    localparam int ext_cyc[4] = '{20, 40, 60, 80};
    localparam int to_cyc[4] = '{30, 25, 20, 15};
    logic [7:0] rst_tab[4] = '{8'h03, 8'h00, 8'h00, `SCR_ID_BASE | 8'h10};
    logic [7:0] en_tab[5] = '{8'h80, 8'h04, 8'h08, 8'h01, 8'h00};
    logic [3:0] fl_tab[5] = '{4'h8, 4'h4, 4'h1, 4'h2, 4'hF};
    row_type rows[11] = '{
        '{OP_DIAG, 1'b0, 2'h0, 8'hFF, 1'b1, 8'h33, 7'h52}, '{OP_DIAG, 1'b0, 2'h0, 8'h23, 1'b1, 8'h23, 7'h52},
        '{OP_DIAG, 1'b0, 2'h0, 8'h13, 1'b1, 8'h13, 7'h48}, '{OP_DIAG, 1'b0, 2'h1, 8'hFF, 1'b1, 8'h3F, 7'h48},
        '{OP_DIAG, 1'b0, 2'h2, 8'hFF, 1'b1, 8'hBF, 7'h48}, '{OP_ACTIVE, 1'b0, 2'h1, 8'h00, 1'b0, 8'h3F, 7'h48},
        '{OP_DIAG, 1'b1, 2'h2, 8'h00, 1'b0, 8'hBF, 7'h48}, '{OP_SAFE, 1'b0, 2'h0, 8'h00, 1'b0, 8'h13, 7'h48},
        '{OP_RESET, 1'b0, 2'h0, 8'h00, 1'b0, 8'h13, 7'h48}, '{OP_DIAG, 1'b0, 2'h3, 8'h00, 1'b0, `SCR_ID_BASE, 7'h48},
        '{OP_DIAG, 1'b0, 2'h0, 8'hCC, 1'b1, 8'h00, 7'h3E}};

    safety_config_registers #(.EXT0_CYC(27'(ext_cyc[0])), .EXT1_CYC(27'(ext_cyc[1])), .EXT2_CYC(27'(ext_cyc[2])),
        .EXT3_CYC(27'(ext_cyc[3])), .TO0_CYC(27'(to_cyc[0])), .TO1_CYC(27'(to_cyc[1])), .TO2_CYC(27'(to_cyc[2])),
        .TO3_CYC(27'(to_cyc[3]))) dut (.clock_in(clock_in), .srst_in(srst_in), .cmd_in(cmd),
        .rd_data_out(rd_data), .rd_valid_out(rd_valid), .wr_ack_out(wr_ack), .wr_reject_out(wr_rej),
        .op_state_in(op), .cfg_lock_in(lock), .delay_order_fuse_in(fuse), .device_error_count_in(err_cnt),
        .safe_timeout_disable_in(dis), .faults_in(faults), .reset_ext_start_in(ext_start),
        .supply_low_threshold_out(thr), .safety_config_2_out(cfg2), .config_checksum_out(csum),
        .mcu_reset_out_n(mcu_rst_n), .go_safe_out(go_safe), .go_reset_out(go_reset), .safe_locked_out(locked));
    scr_mcu_model mcu (.clock_in(clock_in), .cmd_out(cmd), .rd_data_in(rd_data), .rd_valid_in(rd_valid),
        .wr_ack_in(wr_ack), .wr_reject_in(wr_rej));

    initial begin
        clock_in = 1'b0;
        forever #4 clock_in = ~clock_in;
    end
    task automatic chk(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask : chk
    // Reference checksum: polynomial 0x07, seed all ones, most significant bit first.
    function automatic logic [7:0] crc_ref(input logic [23:0] d);
        logic [7:0] c;
        c = 8'hFF;
        for (int i = 23; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
        end
        return c;
    endfunction : crc_ref
    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test
    task automatic do_reset(input logic f);
        @(posedge clock_in);
        #1 srst_in = 1'b1;
        fuse = f;
        op = OP_RESET;
        repeat (16) @(posedge clock_in);
        #1 srst_in = 1'b0;
        repeat (2) @(posedge clock_in);
        #1 op = OP_DIAG;
    endtask : do_reset
    task automatic wcfg(input logic [1:0] sel, input logic [7:0] data);
        op = OP_DIAG;
        lock = 1'b0;
        mcu.write(sel, data, wresp);
    endtask : wcfg
    task automatic ext_test(input logic [1:0] code, input int exp);
        wcfg(2'h0, {6'h00, code});
        @(posedge clock_in);
        #1 ext_start = 1'b1;
        @(posedge clock_in);
        #1 ext_start = 1'b0;
        n = 0;
        while (mcu_rst_n !== 1'b1 && n < 200) begin
            @(posedge clock_in);
            #1 n++;
        end
        chk(n >= exp && n <= exp + 3, "reset extension length");
    endtask : ext_test
    task automatic safe_test(input logic [1:0] code, input logic d, input logic [3:0] cnt, input logic exp_lock);
        wcfg(2'h1, {2'h0, code, 4'h5});
        dis = d;
        err_cnt = cnt;
        op = OP_SAFE;
        n = 0;
        while (go_reset !== 1'b1 && n < to_cyc[code] + 12) begin
            @(posedge clock_in);
            #1 n++;
        end
        if (exp_lock) chk(locked === 1'b1 && go_reset !== 1'b1, "safe lock");
        else chk(n >= to_cyc[code] && n <= to_cyc[code] + 5, "safe time-out length");
        op = OP_DIAG;
        dis = 1'b0;
        err_cnt = 4'h0;
    endtask : safe_test

    initial begin
        #200000;
        n_fail++;
        $display("unexpected at %0t: watchdog expired", $time);
        end_of_test();
    end
    initial begin
        srst_in = 1'b1;
        op = OP_RESET;
        {lock, fuse, dis, ext_start} = 4'h0;
        err_cnt = 4'h0;
        faults = 4'h0;
        do_reset(1'b0);
        foreach (rows[i]) begin
            op = rows[i].op;
            lock = rows[i].lock;
            mcu.write(rows[i].sel, rows[i].data, wresp);
            chk(wresp === {rows[i].ack, ~rows[i].ack}, "write response");
            op = OP_DIAG;
            lock = 1'b0;
            mcu.read(rows[i].sel, rresp);
            chk(rresp === {1'b1, rows[i].rd} && thr === rows[i].thr, "read back");
        end
        chk(csum === crc_ref({8'h00, 8'h3F, 8'hBF}), "checksum after writes");
        for (int c = 0; c < 4; c++) ext_test(2'(c), ext_cyc[c]);
        do_reset(1'b1);
        chk(thr === 7'h3E && csum === crc_ref(24'h03_0000), "threshold or checksum after reset");
        for (int s = 0; s < 4; s++) begin
            mcu.read(2'(s), rresp);
            chk(rresp === {1'b1, rst_tab[s]}, "reset value or identity");
        end
        for (int c = 0; c < 4; c++) ext_test(2'(c), ext_cyc[3 - c]);
        for (int c = 0; c < 4; c++) safe_test(2'(c), 1'b0, 4'hF, 1'b0);
        safe_test(2'h0, 1'b1, 4'h5, 1'b0);
        safe_test(2'h0, 1'b1, 4'h6, 1'b1);
        for (int i = 0; i < 5; i++) begin
            wcfg(2'h2, en_tab[i]);
            op = OP_ACTIVE;
            faults = fl_tab[i];
            repeat (2) @(posedge clock_in);
            #1 chk(go_safe === (i < 4) && go_reset === 1'b0, "fault response");
            faults = 4'h0;
        end
        wcfg(2'h2, 8'h03);
        op = OP_ACTIVE;
        faults = 4'h2;
        repeat (2) @(posedge clock_in);
        #1 chk(go_reset === 1'b1 && go_safe === 1'b0, "reset priority");
        end_of_test();
    end
endmodule : tb_top
